// >>> verification/rtsq_timer_model.sv
// Behavioural release timer: crystal, first divider, select gate, down counter, firing switch
`timescale 1ns/1ps

module rtsq_timer_model #(
  parameter int XTAL_HALF_NS = 100,
  parameter int DIV1 = 64,
  parameter int DIV2N = 4,
  parameter int PRESET = 5,
  parameter int FIRE_DLY_NS = 3000
) (
  input wire logic test_clk,
  input wire logic sel_normal,
  input wire logic sel_test,
  input wire logic load,
  input wire logic relay,
  output logic mux_out,
  output logic div2_out,
  output logic fire_det
);
  logic xtal = 1'b0;
  logic div1_out = 1'b0;
  logic div2_q = 1'b0;
  logic indicator_a = 1'b0;
  logic zero_dly;
  int div1_cnt = 0;
  int div2_cnt = 0;
  int down = PRESET;

  // Free running crystal
  initial forever #(XTAL_HALF_NS) xtal = ~xtal;

  // First divider, square output
  always @(posedge xtal) begin
    div1_cnt <= (div1_cnt == DIV1 / 2 - 1) ? 0 : div1_cnt + 1;
    if (div1_cnt == DIV1 / 2 - 1) div1_out <= ~div1_out;
  end

  // Select gate: own divider or the test clock
  assign mux_out = (sel_normal & div1_out) | (sel_test & test_clk);

  // Second divider
  always @(posedge mux_out) begin
    div2_cnt <= (div2_cnt == DIV2N / 2 - 1) ? 0 : div2_cnt + 1;
    if (div2_cnt == DIV2N / 2 - 1) div2_q <= ~div2_q;
  end
  assign div2_out = div2_q;

  // Down counter reloads from the switches while reset is held
  always @(posedge div2_out or posedge load) begin
    if (load) down <= PRESET;
    else if (down != 0) down <= down - 1;
  end

  // Low-pass delay stops count spikes from firing; switch latches only with relay closed
  assign #(FIRE_DLY_NS) zero_dly = (down == 0);
  always @(posedge zero_dly or negedge relay) indicator_a <= zero_dly & relay;
  assign fire_det = indicator_a & relay;
endmodule : rtsq_timer_model

// >>> verification/tb_top.sv
// Self-checking bench for the release timer test sequencer
`timescale 1ns/1ps
`include "rtsq_cfg.svh"

module tb_top;
  localparam int REF_DIV = 10;
  localparam int PRESCALE = 2;
  localparam int DIV2N = 4;
  localparam int PRESET = 5;
  localparam int TICK = REF_DIV * `RTSQ_BASE_DIV;
  logic ref_clk = 1'b0;
  logic reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_d;
  logic pready, pslverr, rd_e, meas_in, div2_in, fire_det;
  logic start_btn = 1'b0;
  logic reset_btn = 1'b0;
  logic timer_reset = 1'b0;
  logic test_clk, sel_normal, sel_test, timer_load, relay, indicator, irq;
  logic [3:0] blank;
  logic [15:0] disp;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  // ------
  // Design and timer
  // ------
  rtsq_top #(.REF_DIV(REF_DIV), .PRESCALE(PRESCALE)) dut (.REF_CLK(ref_clk), .RESET(reset),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MEAS_IN(meas_in),
    .DIV2_IN(div2_in), .FIRE_DET(fire_det), .START_BTN(start_btn), .RESET_BTN(reset_btn),
    .TIMER_RESET(timer_reset), .TEST_CLK(test_clk), .SEL_NORMAL(sel_normal),
    .SEL_TEST(sel_test), .TIMER_LOAD(timer_load), .SQUIB_PATH_RELAY(relay),
    .INDICATOR_A(indicator), .DIGIT_BLANK(blank), .DISP_DATA(disp), .IRQ(irq));
  rtsq_timer_model #(.DIV2N(DIV2N), .PRESET(PRESET)) timer (.test_clk(test_clk),
    .sel_normal(sel_normal), .sel_test(sel_test), .load(timer_load), .relay(relay),
    .mux_out(meas_in), .div2_out(div2_in), .fire_det(fire_det));

  // 40 MHz clock
  initial forever #12.5 ref_clk = ~ref_clk;

  // Hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ------
  // Checking helpers
  // ------
  task automatic print_verdict;
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Range check; BCD keeps numeric order
  task automatic cmp_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : cmp_rng

  function automatic logic [15:0] to_bcd(input int n);
    return {4'(n / 1000 % 10), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
  endfunction : to_bcd

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    cmp(pready, 1'b1);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : apb

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    cmp(irq, 1'b1);
  endtask : wait_irq

  // Reset from the test set or from the timer, held for a few cycles
  task automatic press(input logic from_timer);
    if (from_timer) timer_reset <= 1'b1;
    else reset_btn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cmp({relay, timer_load, sel_normal, sel_test}, 4'b0110);
    reset_btn <= 1'b0;
    timer_reset <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cmp(disp, 16'h0);
  endtask : press

  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    apb(1'b0, `RTSQ_REG_CTRL, 32'h0);
    cmp(rd_d, 32'h0);
    apb(1'b0, `RTSQ_REG_STATUS, 32'h0);
    cmp(rd_d[8:0] & 9'h1EF, 9'h001);
    cmp({sel_normal, sel_test, relay}, 3'b100);
  endtask : t_regs

  // One digit lit, moving on each reference tick
  task automatic t_rotate;
    logic [3:0] v;
    int n;
    n = 0;
    v = blank;
    while (blank === v && n < 2 * TICK) begin
      @(negedge ref_clk);
      n++;
    end
    for (int i = 0; i < 5; i++) begin
      v = blank;
      cmp($countones(blank), 3);
      repeat (TICK) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp(blank, {v[2:0], v[3]});
    end
    @(posedge ref_clk);
  endtask : t_rotate

  // Divider last then hour, so the hour entry must clear a set gate
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `RTSQ_REG_CTRL, 32'(m));
      cmp({sel_normal, sel_test, relay}, {m != 2, m == 2, m == 3});
    end
  endtask : t_modes

  // Second complete counting cycle gives the result
  task automatic meas_test(input logic [1:0] m, input int lo, input int hi);
    apb(1'b1, `RTSQ_REG_INT_MASK, 32'h1);
    apb(1'b1, `RTSQ_REG_CTRL, {30'h0, m});
    repeat (2) begin
      apb(1'b1, `RTSQ_REG_INT_STAT, 32'h3);
      wait_irq();
    end
    apb(1'b0, `RTSQ_REG_RESULT, 32'h0);
    cmp_rng(rd_d[15:0], to_bcd(lo), to_bcd(hi));
    cmp(rd_d[15:0], disp);
  endtask : meas_test

  task automatic t_irq;
    apb(1'b1, `RTSQ_REG_INT_MASK, 32'h0);
    cmp(irq, 1'b0);
    apb(1'b1, `RTSQ_REG_INT_MASK, 32'h1);
    cmp(irq, 1'b1);
    apb(1'b1, `RTSQ_REG_INT_STAT, 32'h1);
    cmp(irq, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    cmp({rd_e, rd_d}, 33'h100000000);
    apb(1'b0, `RTSQ_REG_INT_MASK, 32'h0);
    cmp(rd_d, 32'h1);
  endtask : t_irq

  task automatic t_hour;
    apb(1'b1, `RTSQ_REG_CTRL, 32'h3);
    apb(1'b1, `RTSQ_REG_INT_MASK, 32'h2);
    apb(1'b1, `RTSQ_REG_INT_STAT, 32'h3);
    press(1'b0);
    cmp(relay, 1'b1);
    start_btn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    start_btn <= 1'b0;
    cmp({sel_normal, sel_test}, 2'b01);
    wait_irq();
    cmp(disp, to_bcd(PRESET));
    cmp(indicator, 1'b1);
    apb(1'b0, `RTSQ_REG_INT_STAT, 32'h0);
    cmp(rd_d, 32'h2);
    repeat (400) @(posedge ref_clk);
    apb(1'b0, `RTSQ_REG_ACCUM, 32'h0);
    cmp(rd_d, to_bcd(PRESET));
    press(1'b1);
    cmp(indicator, 1'b0);
    apb(1'b1, `RTSQ_REG_CTRL, 32'h103);
    cmp({sel_normal, sel_test}, 2'b01);
    apb(1'b1, `RTSQ_REG_CTRL, 32'h203);
    cmp({relay, sel_normal, sel_test, disp}, {3'b110, 16'h0});
  endtask : t_hour

  // ------
  // Main sequence
  // ------
  initial begin
    reset = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_rotate();
    t_modes();
    meas_test(2'd1, 12, 13);
    meas_test(2'd2, 10 * PRESCALE * DIV2N / REF_DIV - 1, 10 * PRESCALE * DIV2N / REF_DIV + 1);
    t_irq();
    t_hour();
    print_verdict();
  end
endmodule : tb_top

// >>> verilog/rtsq_bcd_acc.sv
// Four-decade BCD up counter used as the period and hour accumulator
`timescale 1ns/1ps
`include "rtsq_cfg.svh"

module rtsq_bcd_acc #(
  parameter int DIGITS = `RTSQ_DIGITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic inc,
  output logic [4*DIGITS-1:0] value
);

  typedef struct packed {
    logic [4*DIGITS-1:0] digits;
  } rtsq_acc_t;

  rtsq_acc_t s_r;
  rtsq_acc_t s_nxt;
  logic [DIGITS:0] carry;
  logic [4*DIGITS-1:0] step;

  assign carry[0] = inc;

  // One decade per loop pass; carry ripples, 9999 wraps to 0000
  for (genvar i = 0; i < DIGITS; i++) begin : g_dec
    logic [3:0] d;
    assign d = s_r.digits[4*i +: 4];
    assign carry[i+1] = carry[i] && (d == `RTSQ_BCD_MAX);
    assign step[4*i +: 4] = !carry[i] ? d : (d == `RTSQ_BCD_MAX) ? 4'h0 : d + 4'h1;
  end

  // Clear takes priority over a count in the same cycle
  always_comb begin
    s_nxt = s_r;
    s_nxt.digits = clr ? '0 : step;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign value = s_r.digits;

endmodule : rtsq_bcd_acc

// >>> verilog/rtsq_cfg.svh
// Constants for the release timer test sequencer: rates, counts, register map
`ifndef RTSQ_CFG_SVH
`define RTSQ_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and derived rates
// ----------------------------------------------------------------------------
`define RTSQ_CLK_HZ 40000000
`define RTSQ_BASE_HZ 1000000
`define RTSQ_BASE_DIV (`RTSQ_CLK_HZ / `RTSQ_BASE_HZ)
`define RTSQ_REF_DIV 1000
`define RTSQ_BASE_W 6
`define RTSQ_REF_W 10

// ----------------------------------------------------------------------------
// Measurement counts
// ----------------------------------------------------------------------------
`define RTSQ_PERIODS 10
`define RTSQ_PER_W 4
`define RTSQ_PRESCALE 100
`define RTSQ_PRE_W 7
`define RTSQ_DIGITS 4
`define RTSQ_BCD_MAX 4'h9

// ----------------------------------------------------------------------------
// APB register map (byte addresses) and fields
// ----------------------------------------------------------------------------
`define RTSQ_ADDR_W 8
`define RTSQ_REG_CTRL 8'h00
`define RTSQ_REG_STATUS 8'h04
`define RTSQ_REG_RESULT 8'h08
`define RTSQ_REG_ACCUM 8'h0C
`define RTSQ_REG_INT_STAT 8'h10
`define RTSQ_REG_INT_MASK 8'h14
`define RTSQ_CTRL_MODE_LSB 0
`define RTSQ_CTRL_START_BIT 8
`define RTSQ_CTRL_RESET_BIT 9
`define RTSQ_INT_DONE_BIT 0
`define RTSQ_INT_FIRE_BIT 1
`define RTSQ_INT_W 2
`define RTSQ_SYNC_W 6

`endif

// >>> verilog/rtsq_pkg.sv
// Types shared by the release timer test sequencer modules
`include "rtsq_cfg.svh"

package rtsq_pkg;

  // Test function, one-hot
  typedef enum logic [3:0] {
    SUPPLY_CURRENT_TEST = 4'h1,
    OSCILLATOR_PERIOD_TEST = 4'h2,
    DIVIDER_CHECK_TEST = 4'h4,
    HOUR_INTERVAL_TEST = 4'h8
  } rtsq_mode_t;

  // Whole state of the sequencer top
  typedef struct packed {
    rtsq_mode_t mode;
    logic [`RTSQ_BASE_W-1:0] base_cnt;
    logic [`RTSQ_REF_W-1:0] ref_cnt;
    logic clk_out;
    logic [3:0] seq;
    logic [3:0] blank;
    logic gate;
    logic sel_normal;
    logic sel_test;
    logic relay;
    logic indicator;
    logic capture;
    logic load;
    logic phase;
    logic [`RTSQ_PER_W-1:0] per_cnt;
    logic [`RTSQ_PRE_W-1:0] pre_cnt;
    logic meas_prev;
    logic div2_prev;
    logic fire_prev;
    logic start_prev;
    logic [15:0] disp;
    logic [`RTSQ_INT_W-1:0] int_stat;
    logic [`RTSQ_INT_W-1:0] int_mask;
    logic irq;
    logic sw_start;
    logic sw_reset;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rtsq_state_t;

endpackage : rtsq_pkg

// >>> verilog/rtsq_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps

module rtsq_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } rtsq_sync_t;

  rtsq_sync_t s_r;
  rtsq_sync_t s_nxt;

  // Stage one feeds only stage two
  always_comb begin
    s_nxt = s_r;
    s_nxt.stage1 = d;
    s_nxt.stage2 = s_r.stage1;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stage2;

endmodule : rtsq_sync

// >>> verilog/rtsq_top.sv
// Release timer test sequencer: mode control, period meter, hour capture, APB
`timescale 1ns/1ps
`include "rtsq_cfg.svh"

// Contract
// - 1 MHz base, divided by 1000 to 1 kHz
// - One of four digits lit, rotating each ms
// - Blanking inputs driven, stored digit kept
// - Current test holds gate reset
// - Oscillator test averages ten periods at 0.1 ms
// - Reference gated ten periods on, ten off
// - Accumulator cleared before each count
// - Divider test forces gate set
// - Divider output prescaled by 100
// - Entering hour test resets gate
// - Relay energized only in hour test
// - Reset clears accumulators, latch, gate except in divider test; loads timer
// - Relay off while reset held
// - Start sets gate; pulses increment accumulator
// - Firing sets latch, strobes count to display
// - Indicator on while firing current detected
module rtsq_top #(
  parameter int BASE_DIV = `RTSQ_BASE_DIV,
  parameter int REF_DIV = `RTSQ_REF_DIV,
  parameter int PERIODS = `RTSQ_PERIODS,
  parameter int PRESCALE = `RTSQ_PRESCALE
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`RTSQ_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MEAS_IN,
  input wire logic DIV2_IN,
  input wire logic FIRE_DET,
  input wire logic START_BTN,
  input wire logic RESET_BTN,
  input wire logic TIMER_RESET,
  output logic TEST_CLK,
  output logic SEL_NORMAL,
  output logic SEL_TEST,
  output logic TIMER_LOAD,
  output logic SQUIB_PATH_RELAY,
  output logic INDICATOR_A,
  output logic [3:0] DIGIT_BLANK,
  output logic [15:0] DISP_DATA,
  output logic IRQ
);

  // --------------------------------------------------------------------------
  // Local constants
  // --------------------------------------------------------------------------
  localparam logic [`RTSQ_BASE_W-1:0] BASE_LAST = `RTSQ_BASE_W'(BASE_DIV - 1);
  localparam logic [`RTSQ_BASE_W-1:0] BASE_HALF = `RTSQ_BASE_W'(BASE_DIV / 2);
  localparam logic [`RTSQ_REF_W-1:0] REF_LAST = `RTSQ_REF_W'(REF_DIV - 1);
  localparam logic [`RTSQ_PER_W-1:0] PER_LAST = `RTSQ_PER_W'(PERIODS - 1);
  localparam logic [`RTSQ_PRE_W-1:0] PRE_LAST = `RTSQ_PRE_W'(PRESCALE - 1);
  localparam int A_BASE_DIV = `RTSQ_BASE_DIV;

  rtsq_pkg::rtsq_state_t s_r;
  rtsq_pkg::rtsq_state_t s_nxt;

  logic [`RTSQ_SYNC_W-1:0] pins_s;
  logic meas_s;
  logic div2_s;
  logic fire_s;
  logic start_s;
  logic btn_rst_s;
  logic tmr_rst_s;
  logic rst_any_s;
  logic [15:0] acc;
  logic acc_clr;
  logic acc_inc;
  logic tick_1m;
  logic tick_1k;
  logic meas_rise;
  logic div2_rise;
  logic fire_rise;
  logic start_any;
  logic reset_any;
  logic meas_ev;
  logic apb_acc;
  logic [31:0] rd;

  // --------------------------------------------------------------------------
  // Pin synchronisers and accumulator
  // --------------------------------------------------------------------------

  // All asynchronous pins pass two flops first
  rtsq_sync #(
    .W(`RTSQ_SYNC_W)
  ) u_sync (
    .clk(REF_CLK),
    .rst(RESET),
    .d({MEAS_IN, DIV2_IN, FIRE_DET, START_BTN, RESET_BTN, TIMER_RESET}),
    .q(pins_s)
  );

  assign {meas_s, div2_s, fire_s, start_s, btn_rst_s, tmr_rst_s} = pins_s;
  assign rst_any_s = btn_rst_s || tmr_rst_s;

  // Decade accumulator shared by period and hour measurement
  rtsq_bcd_acc #(
    .DIGITS(`RTSQ_DIGITS)
  ) u_acc (
    .clk(REF_CLK),
    .rst(RESET),
    .clr(acc_clr),
    .inc(acc_inc),
    .value(acc)
  );

  // Edges seen on synchronised levels only, so each counts once
  assign meas_rise = meas_s && !s_r.meas_prev;
  assign div2_rise = div2_s && !s_r.div2_prev;
  assign fire_rise = fire_s && !s_r.fire_prev;
  assign start_any = (start_s && !s_r.start_prev) || s_r.sw_start;
  assign reset_any = rst_any_s || s_r.sw_reset;
  assign apb_acc = PSEL && PENABLE && !s_r.pready;

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  always_comb begin
    rd = '0;
    unique case (PADDR)
      `RTSQ_REG_CTRL: begin
        unique case (s_r.mode)
          rtsq_pkg::SUPPLY_CURRENT_TEST: rd[1:0] = 2'h0;
          rtsq_pkg::OSCILLATOR_PERIOD_TEST: rd[1:0] = 2'h1;
          rtsq_pkg::DIVIDER_CHECK_TEST: rd[1:0] = 2'h2;
          rtsq_pkg::HOUR_INTERVAL_TEST: rd[1:0] = 2'h3;
          default: rd[1:0] = 2'h0;
        endcase
      end
      `RTSQ_REG_STATUS: rd[8:0] = {s_r.gate, s_r.relay, s_r.capture, s_r.indicator,
                                   s_r.phase, s_r.mode};
      `RTSQ_REG_RESULT: rd[15:0] = s_r.disp;
      `RTSQ_REG_ACCUM: rd[15:0] = acc;
      `RTSQ_REG_INT_STAT: rd[`RTSQ_INT_W-1:0] = s_r.int_stat;
      `RTSQ_REG_INT_MASK: rd[`RTSQ_INT_W-1:0] = s_r.int_mask;
      default: rd = '0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic [`RTSQ_INT_W-1:0] int_set;
    logic [`RTSQ_INT_W-1:0] int_clr;
    int_set = '0;
    int_clr = '0;
    s_nxt = s_r;
    acc_clr = 1'b0;
    acc_inc = 1'b0;
    meas_ev = 1'b0;

    // Base and reference dividers, both as enable pulses
    tick_1m = (s_r.base_cnt == BASE_LAST);
    tick_1k = tick_1m && (s_r.ref_cnt == REF_LAST);
    s_nxt.base_cnt = tick_1m ? '0 : s_r.base_cnt + 1'b1;
    if (tick_1m) begin
      s_nxt.ref_cnt = tick_1k ? '0 : s_r.ref_cnt + 1'b1;
    end
    s_nxt.clk_out = (s_nxt.base_cnt < BASE_HALF);

    // Digit rotation at 1 kHz; blanking keeps digit memory intact
    if (tick_1k) begin
      s_nxt.seq = {s_r.seq[2:0], s_r.seq[3]};
    end
    s_nxt.blank = ~s_nxt.seq;

    s_nxt.meas_prev = meas_s;
    s_nxt.div2_prev = div2_s;
    s_nxt.fire_prev = fire_s;
    s_nxt.start_prev = start_s;
    s_nxt.sw_start = 1'b0;
    s_nxt.sw_reset = 1'b0;
    s_nxt.indicator = fire_s;
    s_nxt.load = rst_any_s || s_r.sw_reset;

    // Gate flip-flop per function
    unique case (s_r.mode)
      rtsq_pkg::SUPPLY_CURRENT_TEST, rtsq_pkg::OSCILLATOR_PERIOD_TEST: begin
        s_nxt.gate = 1'b0;
      end
      rtsq_pkg::DIVIDER_CHECK_TEST: begin
        s_nxt.gate = 1'b1;
      end
      rtsq_pkg::HOUR_INTERVAL_TEST: begin
        if (reset_any) begin
          s_nxt.gate = 1'b0;
        end else if (start_any) begin
          s_nxt.gate = 1'b1;
        end
      end
      default: s_nxt.gate = 1'b0;
    endcase

    // Relay closed only in hour test and never while reset is held
    s_nxt.relay = (s_r.mode == rtsq_pkg::HOUR_INTERVAL_TEST) && !reset_any;

    // Measured event: oscillator edge or divider output after prescale
    if (s_r.mode == rtsq_pkg::OSCILLATOR_PERIOD_TEST) begin
      meas_ev = meas_rise;
    end else if (s_r.mode == rtsq_pkg::DIVIDER_CHECK_TEST && div2_rise) begin
      meas_ev = (s_r.pre_cnt == PRE_LAST);
      s_nxt.pre_cnt = meas_ev ? '0 : s_r.pre_cnt + 1'b1;
    end

    if (s_r.mode == rtsq_pkg::HOUR_INTERVAL_TEST) begin
      // Each timer pulse counts while the gate is set, until the firing latch closes
      acc_inc = div2_rise && s_r.gate && !s_r.capture;
      if (fire_rise && !s_r.capture) begin
        s_nxt.capture = 1'b1;
        s_nxt.disp = acc;
        int_set[`RTSQ_INT_FIRE_BIT] = 1'b1;
      end
      s_nxt.phase = 1'b0;
      s_nxt.per_cnt = '0;
    end else if (s_r.mode == rtsq_pkg::SUPPLY_CURRENT_TEST) begin
      s_nxt.phase = 1'b0;
      s_nxt.per_cnt = '0;
    end else begin
      // Ten periods gated on, ten off; count 1 kHz while on
      acc_inc = s_r.phase && tick_1k;
      if (meas_ev) begin
        s_nxt.per_cnt = (s_r.per_cnt == PER_LAST) ? '0 : s_r.per_cnt + 1'b1;
        if (s_r.per_cnt == PER_LAST) begin
          s_nxt.phase = !s_r.phase;
          if (!s_r.phase) begin
            acc_clr = 1'b1;
          end else begin
            s_nxt.disp = acc;
            int_set[`RTSQ_INT_DONE_BIT] = 1'b1;
          end
        end
      end
    end

    // Either unit's reset clears the count, the display and the latch
    if (reset_any) begin
      acc_clr = 1'b1;
      s_nxt.disp = '0;
      s_nxt.capture = 1'b0;
      s_nxt.phase = 1'b0;
      s_nxt.per_cnt = '0;
      s_nxt.pre_cnt = '0;
    end

    // APB slave: one wait state, answer registered
    s_nxt.pready = apb_acc;
    s_nxt.pslverr = 1'b0;
    if (apb_acc) begin
      s_nxt.pslverr = !(PADDR inside {`RTSQ_REG_CTRL, `RTSQ_REG_STATUS, `RTSQ_REG_RESULT,
                                      `RTSQ_REG_ACCUM, `RTSQ_REG_INT_STAT,
                                      `RTSQ_REG_INT_MASK});
      s_nxt.prdata = PWRITE ? '0 : rd;
      if (PWRITE) begin
        unique case (PADDR)
          `RTSQ_REG_CTRL: begin
            unique case (PWDATA[`RTSQ_CTRL_MODE_LSB +: 2])
              2'h0: s_nxt.mode = rtsq_pkg::SUPPLY_CURRENT_TEST;
              2'h1: s_nxt.mode = rtsq_pkg::OSCILLATOR_PERIOD_TEST;
              2'h2: s_nxt.mode = rtsq_pkg::DIVIDER_CHECK_TEST;
              2'h3: s_nxt.mode = rtsq_pkg::HOUR_INTERVAL_TEST;
            endcase
            if (s_nxt.mode == rtsq_pkg::HOUR_INTERVAL_TEST &&
                s_r.mode != rtsq_pkg::HOUR_INTERVAL_TEST) begin
              s_nxt.gate = 1'b0;
            end
            s_nxt.sw_start = PWDATA[`RTSQ_CTRL_START_BIT];
            s_nxt.sw_reset = PWDATA[`RTSQ_CTRL_RESET_BIT];
          end
          `RTSQ_REG_INT_STAT: int_clr = PWDATA[`RTSQ_INT_W-1:0];
          `RTSQ_REG_INT_MASK: s_nxt.int_mask = PWDATA[`RTSQ_INT_W-1:0];
          default: int_clr = '0;
        endcase
      end
    end

    // Sticky events; a set in the clearing cycle wins
    s_nxt.int_stat = (s_r.int_stat & ~int_clr) | int_set;
    s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);
    s_nxt.sel_normal = !s_nxt.gate;
    s_nxt.sel_test = s_nxt.gate;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      s_r <= '0;
      s_r.mode <= rtsq_pkg::SUPPLY_CURRENT_TEST;
      s_r.seq <= 4'h1;
      s_r.blank <= 4'hE;
      s_r.sel_normal <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign TEST_CLK = s_r.clk_out;
  assign SEL_NORMAL = s_r.sel_normal;
  assign SEL_TEST = s_r.sel_test;
  assign TIMER_LOAD = s_r.load;
  assign SQUIB_PATH_RELAY = s_r.relay;
  assign INDICATOR_A = s_r.indicator;
  assign DIGIT_BLANK = s_r.blank;
  assign DISP_DATA = s_r.disp;
  assign IRQ = s_r.irq;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_hour_start;
    s_r.mode == rtsq_pkg::HOUR_INTERVAL_TEST && start_any && !reset_any;
  endsequence

  sequence s_gate_routed;
    s_r.gate && SEL_TEST && !SEL_NORMAL;
  endsequence

  a_base_rate: assert property (tick_1m |-> ##A_BASE_DIV tick_1m)
    else $error("base enable not every 40 cycles");
  a_one_digit_lit: assert property ($countones(~DIGIT_BLANK) == 1)
    else $error("not exactly one digit lit");
  a_digit_rotate: assert property (tick_1k |=> s_r.seq == {$past(s_r.seq[2:0]), $past(s_r.seq[3])})
    else $error("digit sequencer did not advance");
  a_gate_current: assert property ((s_r.mode == rtsq_pkg::SUPPLY_CURRENT_TEST) [*2] |-> SEL_NORMAL && !SEL_TEST)
    else $error("gate not reset in current test");
  a_gate_divider: assert property ((s_r.mode == rtsq_pkg::DIVIDER_CHECK_TEST) [*2] |-> s_gate_routed)
    else $error("gate not set in divider test");
  a_hour_start: assert property (s_hour_start |=> s_gate_routed)
    else $error("start did not set gate");
  a_relay_mode: assert property (SQUIB_PATH_RELAY |-> $past(s_r.mode) == rtsq_pkg::HOUR_INTERVAL_TEST)
    else $error("relay energized outside hour test");
  a_relay_reset: assert property (reset_any |=> !SQUIB_PATH_RELAY)
    else $error("relay energized during reset");
  a_reset_clears: assert property (reset_any |=> DISP_DATA == 16'h0 && !s_r.capture ##0 acc == 16'h0)
    else $error("reset did not clear count and latch");
  a_capture_disp: assert property ($rose(s_r.capture) |-> DISP_DATA == $past(acc))
    else $error("capture did not strobe accumulator");
  a_clear_first: assert property ($rose(s_r.phase) |-> acc == 16'h0)
    else $error("accumulator not cleared at gate open");
  a_phase_flip: assert property (meas_ev && s_r.per_cnt == PER_LAST && !reset_any |=> s_r.phase != $past(s_r.phase))
    else $error("reference gate did not toggle after ten periods");
  a_indicator_a_lamp: assert property (fire_s |=> INDICATOR_A)
    else $error("indicator not lit on firing current");

endmodule : rtsq_top
